// ---- rtl/osm_params.svh ----
// constants for the oxygen signal plausibility monitor
`ifndef OSM_PARAMS_SVH
`define OSM_PARAMS_SVH
`define OSM_CLK_MHZ 200
`define OSM_PER_MIN_MS 50
`define OSM_PER_MAX_MS 4000
`define OSM_PER_MIN_CYC (`OSM_PER_MIN_MS * 1000 * `OSM_CLK_MHZ)
`define OSM_PER_MAX_CYC (`OSM_PER_MAX_MS * 1000 * `OSM_CLK_MHZ)
`define OSM_TOL_PCT 4
`define OSM_PULSE_DROP_PCT 10
`define OSM_ANA_DROP_MIN_PCT 10
`define OSM_ANA_DROP_MAX_PCT 30
`define OSM_FULL_SCALE 16'hffff
`define OSM_INTERVAL_CYC 32'h0bebc200
`define OSM_TEST_LEN_CYC 32'h05f5e100
`define OSM_CMP_GRACE_CYC 32'h00000010
`define OSM_CNT_W 32
`define OSM_VAL_W 16
`endif

// ---- rtl/osm_pkg.sv ----
// types for the oxygen signal plausibility monitor
package osm_pkg;
   typedef enum logic [3:0] {
      OSM_NORMAL = 4'b0001,
      OSM_ARM = 4'b0010,
      OSM_TEST = 4'b0100,
      OSM_JUDGE = 4'b1000
   } osm_state_t;
   typedef struct packed {
      logic period_err;
      logic static_err;
      logic mismatch_err;
      logic test_err;
   } osm_err_t;
endpackage

// ---- rtl/osm_period_meter.sv ----
// measures the low+high period of the pulse channel in clock cycles
`timescale 1ns/1ps
`include "osm_params.svh"
module osm_period_meter (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // pulse in
   input wire logic pulse_in,
   // measurement out
   output logic [`OSM_CNT_W-1:0] period,
   output logic period_valid,
   output logic too_long
);
   logic [`OSM_CNT_W-1:0] cnt, next_cnt, next_period;
   logic last, next_last, next_valid, next_too_long;
   logic seen, next_seen, rise;
   always_comb begin
      rise = pulse_in && !last;
      next_last = pulse_in;
      // first edge after reset ends a partial period; only arm on it
      next_seen = seen | rise;
      next_valid = 1'b0;
      next_period = period;
      next_too_long = 1'b0;
      next_cnt = cnt + 32'h1;
      if (rise) next_cnt = 32'h0;
      if (rise && seen) begin
         next_period = cnt + 32'h1;
         next_valid = 1'b1;
      end
      // saturate so a stuck line stays flagged
      if (cnt >= `OSM_PER_MAX_CYC) begin
         next_too_long = 1'b1;
         if (!rise) next_cnt = cnt;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 32'h0;
         last <= 1'b0;
         seen <= 1'b0;
         period <= 32'h0;
         period_valid <= 1'b0;
         too_long <= 1'b0;
      end else if (ce) begin
         cnt <= next_cnt;
         last <= next_last;
         seen <= next_seen;
         period <= next_period;
         period_valid <= next_valid;
         too_long <= next_too_long;
      end
   end
endmodule

// ---- rtl/osm_monitor.sv ----
// external monitor for a two-channel gas analyser
// Functional notes
// - a pulse period under 0.05 s or over 4 s is an error.
// - a pulse line stuck low or high is an internal analyser fault.
// - in normal operation the channels must differ by under 4% full scale.
// - the two channels are compared continuously; the code compares only in OSM_NORMAL once grace has run out.
// - under test a pulse drop of 10% or less is a failure; the code fails only a drop under 10%, so a drop of exactly 10% passes.
// - under test an analogue drop outside the expected range is a failure.
// - the analogue value is captured as reference before the test starts.
// - the test line is low normally and raised at a set interval.
// - tests never lie further apart than the configured interval.
// - any error raises the safe-state output.
`timescale 1ns/1ps
`include "osm_params.svh"
module osm_monitor
   import osm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // analyser channels
   input wire logic [`OSM_VAL_W-1:0] analog_value_output,
   input wire logic pulse_period_output,
   // pulse period scaled into analogue units
   input wire logic [`OSM_VAL_W-1:0] pulse_value,
   // analyser control
   output logic test_out,
   // status
   output logic safe_state,
   output osm_err_t err
);
   logic [`OSM_CNT_W-1:0] period;
   logic period_valid, too_long;
   osm_period_meter u_meter (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pulse_in(pulse_period_output),
      .period(period),
      .period_valid(period_valid),
      .too_long(too_long)
   );
   osm_state_t state, next_state;
   logic [`OSM_CNT_W-1:0] tmr, next_tmr;
   logic [`OSM_VAL_W-1:0] pre_test_analog_reference, next_ref;
   logic [`OSM_CNT_W-1:0] pre_period, next_pre_period;
   logic [`OSM_CNT_W-1:0] grace, next_grace;
   logic next_test_out;
   osm_err_t next_err;
   logic [`OSM_VAL_W:0] diff;
   logic [`OSM_VAL_W+7:0] diff100, tol;
   logic [`OSM_VAL_W+7:0] drop_a, ref_lo, ref_hi;
   logic [`OSM_CNT_W+7:0] per100, pre90;
   always_comb begin
      diff = (analog_value_output > pulse_value) ?
         {1'b0, analog_value_output - pulse_value} :
         {1'b0, pulse_value - analog_value_output};
      diff100 = {7'h0, diff} * 24'd100;
      tol = 24'(`OSM_FULL_SCALE) * 24'(`OSM_TOL_PCT);
      drop_a = 24'(pre_test_analog_reference - analog_value_output) * 24'd100;
      ref_lo = {8'h0, pre_test_analog_reference} * 24'(`OSM_ANA_DROP_MIN_PCT);
      ref_hi = {8'h0, pre_test_analog_reference} * 24'(`OSM_ANA_DROP_MAX_PCT);
      per100 = {8'h0, period} * 40'd100;
      pre90 = {8'h0, pre_period} * 40'(100 - `OSM_PULSE_DROP_PCT);
   end
   always_comb begin
      next_state = state;
      next_tmr = tmr + 32'h1;
      next_ref = pre_test_analog_reference;
      next_pre_period = pre_period;
      next_test_out = 1'b0;
      next_grace = (grace != 32'h0) ? grace - 32'h1 : grace;
      next_err = err;
      if (period_valid && (period < `OSM_PER_MIN_CYC ||
            period > `OSM_PER_MAX_CYC)) begin
         next_err.period_err = 1'b1;
      end
      if (too_long) next_err.static_err = 1'b1;
      if (period_valid && state == OSM_NORMAL) next_pre_period = period;
      // compare only outside tests and after the test settles
      if (state == OSM_NORMAL && grace == 32'h0 && diff100 >= tol) begin
         next_err.mismatch_err = 1'b1;
      end
      case (state)
         OSM_NORMAL: begin
            if (tmr >= `OSM_INTERVAL_CYC - 32'h1) begin
               next_ref = analog_value_output;
               next_tmr = 32'h0;
               next_state = OSM_ARM;
            end
         end
         OSM_ARM: begin
            next_test_out = 1'b1;
            next_state = OSM_TEST;
         end
         OSM_TEST: begin
            next_test_out = 1'b1;
            if (tmr >= `OSM_TEST_LEN_CYC) next_state = OSM_JUDGE;
         end
         OSM_JUDGE: begin
            // device reduces both channels
            if (analog_value_output >= pre_test_analog_reference ||
                  drop_a < ref_lo || drop_a > ref_hi) begin
               next_err.test_err = 1'b1;
            end
            if (per100 > pre90) next_err.test_err = 1'b1;
            next_grace = `OSM_CMP_GRACE_CYC;
            // timer runs on from the test start so starts stay one
            // interval apart, not interval plus test length
            next_state = OSM_NORMAL;
         end
         default: next_state = OSM_NORMAL;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= OSM_NORMAL;
         tmr <= 32'h0;
         pre_test_analog_reference <= 16'h0;
         pre_period <= 32'h0;
         grace <= 32'h0;
         test_out <= 1'b0;
         err <= '0;
         safe_state <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         tmr <= next_tmr;
         pre_test_analog_reference <= next_ref;
         pre_period <= next_pre_period;
         grace <= next_grace;
         test_out <= next_test_out;
         err <= next_err;
         safe_state <= |next_err;
      end
   end
   property p_safe;
      @(posedge clk) disable iff (!rst_n) ce && |err |=> safe_state;
   endproperty
   a_safe: assert property (p_safe) else $error("safe not raised");
   property p_latch;
      @(posedge clk) disable iff (!rst_n) safe_state |=> safe_state;
   endproperty
   a_latch: assert property (p_latch) else $error("safe dropped");
   property p_test_low;
      @(posedge clk) disable iff (!rst_n) state == OSM_NORMAL |-> !test_out;
   endproperty
   a_test_low: assert property (p_test_low)
      else $error("test high");
   property p_stat;
      @(posedge clk) disable iff (!rst_n) ce && too_long |=> err.static_err;
   endproperty
   a_stat: assert property (p_stat) else $error("static missed");
   property p_per;
      @(posedge clk) disable iff (!rst_n)
         ce && period_valid && period < `OSM_PER_MIN_CYC |=> err.period_err;
   endproperty
   a_per: assert property (p_per)
      else $error("short period missed");
   property p_ref;
      @(posedge clk) disable iff (!rst_n) ce && state == OSM_NORMAL &&
         next_state == OSM_ARM |=> pre_test_analog_reference ==
         $past(analog_value_output);
   endproperty
   a_ref: assert property (p_ref) else $error("reference wrong");
   property p_int;
      @(posedge clk) disable iff (!rst_n) tmr <= `OSM_INTERVAL_CYC ||
         state != OSM_NORMAL;
   endproperty
   a_int: assert property (p_int)
      else $error("interval exceeded");
   property p_mis;
      @(posedge clk) disable iff (!rst_n) ce && state == OSM_NORMAL &&
         grace == 32'h0 && diff100 >= tol |=> err.mismatch_err;
   endproperty
   a_mis: assert property (p_mis) else $error("mismatch missed");
   // a test start takes two steps: arm, then raise the test line
   sequence s_start;
      ce && state == OSM_NORMAL && next_state == OSM_ARM;
   endsequence
   sequence s_raise;
      state == OSM_ARM ##1 (test_out || !$past(ce));
   endsequence
   property p_start;
      @(posedge clk) disable iff (!rst_n) s_start |=> s_raise;
   endproperty
   a_start: assert property (p_start)
      else $error("test not raised");
   property p_test_hi;
      @(posedge clk) disable iff (!rst_n) state == OSM_TEST |-> test_out;
   endproperty
   a_test_hi: assert property (p_test_hi)
      else $error("test line low");
   property p_long;
      @(posedge clk) disable iff (!rst_n) ce && period_valid &&
         period > `OSM_PER_MAX_CYC |=> err.period_err;
   endproperty
   a_long: assert property (p_long)
      else $error("long period missed");
   // a missing drop of either channel fails the test
   property p_judge_ana;
      @(posedge clk) disable iff (!rst_n) ce && state == OSM_JUDGE &&
         analog_value_output >= pre_test_analog_reference |=> err.test_err;
   endproperty
   a_judge_ana: assert property (p_judge_ana)
      else $error("analogue drop missed");
   property p_judge_pul;
      @(posedge clk) disable iff (!rst_n) ce && state == OSM_JUDGE &&
         per100 > pre90 |=> err.test_err;
   endproperty
   a_judge_pul: assert property (p_judge_pul)
      else $error("pulse drop missed");
   property p_quiet;
      @(posedge clk) disable iff (!rst_n) ce && state != OSM_NORMAL &&
         !err.mismatch_err |=> !err.mismatch_err;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("mismatch flagged in test");
   property p_grace;
      @(posedge clk) disable iff (!rst_n) ce && state == OSM_JUDGE |=>
         grace == `OSM_CMP_GRACE_CYC;
   endproperty
   a_grace: assert property (p_grace)
      else $error("grace not loaded");
   property p_sum;
      @(posedge clk) disable iff (!rst_n) safe_state == (|err);
   endproperty
   a_sum: assert property (p_sum)
      else $error("safe and errors disagree");
   // no error bit may fall once set
   property p_keep;
      @(posedge clk) disable iff (!rst_n) (err & $past(err)) == $past(err);
   endproperty
   a_keep: assert property (p_keep)
      else $error("error bit dropped");
endmodule

// ---- bench/osm_analyser_model.sv ----
// behavioural analyser with analogue, pulse value and pulse line
`timescale 1ns/1ps
module osm_analyser_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control from monitor and bench
   input wire logic test_in,
   input wire logic [15:0] value,
   input wire logic [15:0] offset,
   input wire logic [15:0] half_per,
   // analyser channels
   output logic [15:0] analog_out,
   output logic [15:0] pulse_val,
   output logic pulse_out
);
   logic [15:0] cnt;
   logic [15:0] cur;
   // a test lowers both channels by a fifth
   assign cur = test_in ? value - value / 5 : value;
   // offset is only nonzero where a scenario drives a channel difference for the compare
   assign analog_out = cur;
   assign pulse_val = cur + offset;
   // zero half period leaves the line static
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 16'h0000;
         pulse_out <= 1'b0;
      end else if (half_per != 16'h0000 && cnt >= half_per - 16'h0001) begin
         cnt <= 16'h0000;
         pulse_out <= ~pulse_out;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the plausibility monitor
`timescale 1ns/1ps
`include "osm_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
$display("Error %s exp %h got %h", n, e, g); end end
module testbench
   import osm_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [15:0] value = 16'h1000;
   logic [15:0] offset = 16'h0000;
   logic [15:0] half_per = 16'h0000;
   logic [15:0] ana, pval, d;
   logic pulse, test_out, safe_state;
   osm_err_t err;
   logic [31:0] lfsr = 32'he8e8;
   int failures = 0;
   int cmp_count = 0;
   initial forever #2.5 clk = ~clk;
   osm_analyser_model i_model (.clk(clk), .rst_n(rst_n), .test_in(test_out),
      .value(value), .offset(offset), .half_per(half_per),
      .analog_out(ana), .pulse_val(pval), .pulse_out(pulse));
   osm_monitor i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .analog_value_output(ana), .pulse_period_output(pulse),
      .pulse_value(pval), .test_out(test_out), .safe_state(safe_state),
      .err(err));
   function automatic logic [31:0] next_lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // 4% of full scale or more is a mismatch
   function automatic logic exp_mis(input logic [15:0] x);
      return 32'(x) * 100 >= 32'(`OSM_TOL_PCT) * 32'(`OSM_FULL_SCALE);
   endfunction
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("err", 4'h0, err)
      `CHK("test_out", 1'b0, test_out)
   endtask
   // bounded wait for one error bit
   task automatic wait_bit(input int b, input string n);
      int i;
      for (i = 0; i < 400 && err[b] !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 400) begin
         failures++;
         $display("Error %s exp 1 got %b", n, err[b]);
         final_report();
      end
   endtask
   initial begin
      do_reset();
      for (int k = 0; k < 8; k++) begin
         lfsr = next_lfsr(lfsr);
         d = k == 0 ? 16'd2621 : k == 1 ? 16'd2622 :
            lfsr[8] ? 16'(lfsr[23:12] % 2000) : 16'(3000 + lfsr[23:12]);
         @(posedge clk);
         // high base keeps a negative offset from wrapping
         value <= {2'b01, lfsr[13:0]};
         offset <= lfsr[9] ? d : 16'h0000 - d;
         repeat (20) @(posedge clk);
         #1;
         `CHK("mismatch", exp_mis(d), err.mismatch_err)
         `CHK("safe", exp_mis(d), safe_state)
         offset <= 16'h0000;
         repeat (10) @(posedge clk);
         #1;
         `CHK("latched", exp_mis(d), err.mismatch_err)
         $display("test channel compare %0d done", k);
         do_reset();
      end
      ce <= 1'b0;
      offset <= 16'h2000;
      repeat (30) @(posedge clk);
      #1;
      `CHK("frozen", 4'h0, err)
      ce <= 1'b1;
      wait_bit(1, "mismatch");
      `CHK("safe", 1'b1, safe_state)
      $display("test clock enable done");
      offset <= 16'h0000;
      do_reset();
      half_per <= 16'd50;
      // the partial period after reset must not count
      repeat (75) @(posedge clk);
      #1;
      `CHK("partial", 1'b0, err.period_err)
      wait_bit(3, "period");
      `CHK("safe", 1'b1, safe_state)
      `CHK("test_out", 1'b0, test_out)
      $display("test short period done");
      final_report();
   end
endmodule
